// ---- verilog/simple_serial_shift_port.sv ----
// Serial shift port: 8-bit shift register, bit counter, pins and registers
//
// Contract
// - Eight-bit shift register paired with a four-bit bit counter.
// - Serial data leaves and enters most significant bit first.
// - Register and counter advance on each falling serial clock edge.
// - As master software drives the clock pin by setting and clearing it.
// - After eight clocks the terminal output gates off shifting, freezing the byte.
// - Interrupt on eighth falling edge unless a data write reset the counter.
// - After processor reset the interrupt stays disabled until a data write.
// - Any data register write arms the interrupt for the next eight clocks.
// - Any write to the disarm register disarms the interrupt.
// - The interrupt request is a high-to-low transition.
// - Reset or data write clears the counter and enables the shift clock.
// - Serial input is an input unless software pulls it low; serial output is open-drain for sending.
// - Open-drain serial output connects the shift register MSB to the pin.
// - Serial input pin level stays readable through a port register.
// - As slave software may stretch the clock by driving the pin low.
// - Unused port: no data writes; a dummy disarm write disables interrupts.
`include "sshift_defs.svh"
`default_nettype none

module simple_serial_shift_port
#(
  parameter int ADDR_W = 8
)
(
  // Clock, reset and freeze
  input  wire logic              sys_clk,
  input  wire logic              arst_n,
  input  wire logic              clk_en,
  // Register port
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [7:0]        reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [7:0]        reg_rdata,
  // Interrupts
  output logic                   byte_irq_n,
  output logic                   irq,
  // Serial pins
  input  wire logic              scl_in,
  input  wire logic              sin_in,
  output sshift_pkg::pins_t      pins
);

  // ****************************************
  // Decode
  // ****************************************

  // Address match, used for every register
  function automatic logic hit
  (
    input logic [ADDR_W-1:0] addr,
    input logic [7:0]        off
  );
    hit = (addr == ADDR_W'(off));
  endfunction : hit

  sshift_pkg::state_t st;
  sshift_pkg::state_t next_st;

  logic wr_data;
  logic wr_dis;
  logic scl_fall;
  logic count_terminal_out;
  logic shift_en;
  logic byte_done;

  // Strobe decodes
  assign wr_data = reg_wr && hit(reg_addr, `SSP_OFF_DATA);
  assign wr_dis  = reg_wr && hit(reg_addr, `SSP_OFF_DISARM);

  // Falling edge seen on the second and third sync stages only
  assign scl_fall = st.scl_s3 & ~st.scl_s2;

  // Counter bit 3 ends the byte; low means clock is gated off
  assign count_terminal_out = ~st.cnt[3];

  assign shift_en = scl_fall && count_terminal_out;

  // Eighth edge, not cancelled by a write in the same cycle
  assign byte_done = shift_en
                     && (st.cnt == `SSP_LAST_BIT)
                     && st.armed
                     && !wr_data
                     && !wr_dis;

  // ****************************************
  // Next state
  // ****************************************

  // All next values, built on one copy of the state
  always_comb
  begin
    next_st       = st;
    next_st.rdata = 8'h00;

    // Two-stage synchronisers; the clock pin also feeds an edge stage
    next_st.scl_s1 = scl_in;
    next_st.scl_s2 = st.scl_s1;
    next_st.scl_s3 = st.scl_s2;
    next_st.sin_s1 = sin_in;
    next_st.sin_s2 = st.sin_s1;

    // Shift toward the MSB with the pin into the LSB
    if (shift_en)
    begin
      next_st.sh  = {st.sh[6:0], st.sin_s2};
      next_st.cnt = st.cnt + 4'h1;
    end

    // Request falls on the eighth edge and stays low
    if (byte_done)
    begin
      next_st.irq_n = 1'b0;
    end

    // A data write restarts the byte; it overrides any shift this cycle
    if (wr_data)
    begin
      next_st.sh    = reg_wdata;
      next_st.cnt   = `SSP_RST_CNT;
      next_st.armed = 1'b1;
      next_st.irq_n = 1'b1;
    end

    // Any value disarms; the byte itself keeps going
    if (wr_dis)
    begin
      next_st.disarm = reg_wdata;
      next_st.armed  = 1'b0;
      next_st.irq_n  = 1'b1;
    end

    // Pin configuration
    if (reg_wr && hit(reg_addr, `SSP_OFF_PCTL))
    begin
      next_st.pctl = reg_wdata[4:0];
    end

    if (reg_wr && hit(reg_addr, `SSP_OFF_MASK))
    begin
      next_st.mask = reg_wdata[0];
    end

    // Write one to clear; a new event in the same cycle wins
    if (reg_wr && hit(reg_addr, `SSP_OFF_STAT) && reg_wdata[0])
    begin
      next_st.stat = 1'b0;
    end

    if (byte_done)
    begin
      next_st.stat = 1'b1;
    end

    // Read data stand only in the cycle after the strobe
    if (reg_rd)
    begin
      case (1'b1)
        hit(reg_addr, `SSP_OFF_DATA):
          next_st.rdata = st.sh;
        hit(reg_addr, `SSP_OFF_DISARM):
          next_st.rdata = st.disarm;
        hit(reg_addr, `SSP_OFF_PCTL):
          next_st.rdata = {3'h0, st.pctl};
        hit(reg_addr, `SSP_OFF_PSTAT):
          next_st.rdata = {1'b0,
                           st.cnt,
                           count_terminal_out,
                           st.scl_s2,
                           st.sin_s2};
        hit(reg_addr, `SSP_OFF_STAT):
          next_st.rdata = {7'h00, st.stat};
        hit(reg_addr, `SSP_OFF_MASK):
          next_st.rdata = {7'h00, st.mask};
        default:
          next_st.rdata = 8'h00;
      endcase
    end

    // Clock pin: push-pull, or open-drain that only ever pulls low
    next_st.pins.scl_out  = next_st.pctl[`SSP_PC_SCL_LVL];
    next_st.pins.scl_oe_n = ~(next_st.pctl[`SSP_PC_SCL_EN]
                              && (!next_st.pctl[`SSP_PC_SCL_OD]
                                  || !next_st.pctl[`SSP_PC_SCL_LVL]));

    // Input pin is released unless software pulls it low as acknowledge
    next_st.pins.sin_out  = 1'b0;
    next_st.pins.sin_oe_n = ~next_st.pctl[`SSP_PC_SIN_LOW];

    // Open-drain output follows the MSB; a one releases the line
    next_st.pins.sout_out  = 1'b0;
    next_st.pins.sout_oe_n = next_st.pctl[`SSP_PC_SOUT_OD]
                             ? next_st.sh[7]
                             : 1'b1;

    // Level interrupt from the sticky bit and its mask
    next_st.irq = next_st.stat & next_st.mask;
  end

  // ****************************************
  // State register
  // ****************************************

  // Power-on reset clears the counter and leaves the interrupt disarmed
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st                <= '0;
      st.sh             <= `SSP_RST_BYTE;
      st.cnt            <= `SSP_RST_CNT;
      st.armed          <= 1'b0;
      st.irq_n          <= 1'b1;
      st.pctl           <= `SSP_RST_PCTL;
      st.scl_s1         <= 1'b1;
      st.scl_s2         <= 1'b1;
      st.scl_s3         <= 1'b1;
      st.pins.scl_oe_n  <= 1'b1;
      st.pins.sin_oe_n  <= 1'b1;
      st.pins.sout_oe_n <= 1'b1;
    end
    else if (clk_en)
    begin
      st <= next_st;
    end
  end

  // Outputs straight from the state flip-flops
  assign reg_rdata  = st.rdata;
  assign byte_irq_n = st.irq_n;
  assign irq        = st.irq;
  assign pins       = st.pins;

  // ****************************************
  // Checks
  // ****************************************

  default clocking cb @(posedge sys_clk);
  endclocking

  default disable iff (!arst_n || !clk_en);

  // One accepted shifting edge
  sequence seq_shift;
    shift_en && !wr_data;
  endsequence

  // Last bit of an armed byte
  sequence seq_last_edge;
    seq_shift ##0 (st.cnt == 4'h7) ##0 st.armed ##0 !wr_dis;
  endsequence

  // Byte reaches the frozen state
  sequence seq_frozen;
    (st.cnt == 4'h8) && !count_terminal_out;
  endsequence

  shift_msb_a: assert property (
    seq_shift |=> st.sh == {$past(st.sh[6:0]), $past(st.sin_s2)})
    else $error("shift order wrong");

  count_step_a: assert property (
    seq_shift |=> st.cnt == $past(st.cnt) + 4'h1)
    else $error("counter did not advance");

  byte_freeze_a: assert property (
    !count_terminal_out && !wr_data |=> $stable(st.sh) && $stable(st.cnt))
    else $error("shift after eight clocks");

  irq_fire_a: assert property (
    seq_last_edge |=> seq_frozen ##0 !byte_irq_n ##1 st.stat)
    else $error("no request on eighth edge");

  idle_quiet_a: assert property (
    !st.armed |-> byte_irq_n)
    else $error("request while disarmed");

  write_arm_a: assert property (
    wr_data |=> st.armed && st.cnt == 4'h0 && st.sh == $past(reg_wdata))
    else $error("data write did not arm");

  disarm_write_a: assert property (
    wr_dis && !wr_data |=> !st.armed && byte_irq_n)
    else $error("disarm write ignored");

  irq_fall_a: assert property (
    $fell(byte_irq_n) |-> $past(st.cnt) == 4'h7 && st.cnt == 4'h8)
    else $error("request fell off the eighth edge");

  sout_drive_a: assert property (
    st.pctl[`SSP_PC_SOUT_OD] |-> pins.sout_oe_n == st.sh[7] && !pins.sout_out)
    else $error("output pin not on shift msb");

  sin_read_a: assert property (
    reg_rd && hit(reg_addr, `SSP_OFF_PSTAT) |=> reg_rdata[0] == $past(st.sin_s2))
    else $error("input level not readable");

  clock_hold_a: assert property (
    st.pctl[`SSP_PC_SCL_EN] && !st.pctl[`SSP_PC_SCL_LVL] |-> !pins.scl_oe_n && !pins.scl_out)
    else $error("clock pin not pulled low");

  irq_level_a: assert property (
    st.stat && st.mask |-> ##[0:1] irq)
    else $error("masked level wrong");

  // ****************************************
  // Pin, read port and flag checks
  // ****************************************

  // Read data stand one cycle; the port idles at zero so stale bytes never linger
  read_idle_a: assert property (
    !reg_rd |=> reg_rdata == 8'h00)
    else $error("read data not cleared");

  data_read_a: assert property (
    reg_rd && hit(reg_addr, `SSP_OFF_DATA) |=> reg_rdata == $past(st.sh))
    else $error("data read wrong");

  pstat_count_a: assert property (
    reg_rd && hit(reg_addr, `SSP_OFF_PSTAT) |=> reg_rdata[6:3] == $past(st.cnt))
    else $error("counter not readable");

  count_limit_a: assert property (
    st.cnt <= 4'h8)
    else $error("counter passed eight");

  // The request holds low until software writes the data or disarm register
  irq_hold_a: assert property (
    !byte_irq_n && !wr_data && !wr_dis |=> !byte_irq_n)
    else $error("request rose on its own");

  armed_keep_a: assert property (
    st.armed && !wr_dis |=> st.armed)
    else $error("arming lost");

  // Sticky flag: set by the last edge, kept until a one is written
  stat_set_a: assert property (
    byte_done |=> st.stat)
    else $error("status not set");

  stat_hold_a: assert property (
    st.stat && !(reg_wr && hit(reg_addr, `SSP_OFF_STAT) && reg_wdata[0]) |=> st.stat)
    else $error("status lost");

  mask_gate_a: assert property (
    !st.mask |-> !irq)
    else $error("masked request raised");

  // Open-drain pins may only pull low, so a high level never leaves the block
  drive_open_a: assert property (
    !pins.sin_out && !pins.sout_out)
    else $error("open-drain pin driven high");

  sout_idle_a: assert property (
    !st.pctl[`SSP_PC_SOUT_OD] |-> pins.sout_oe_n)
    else $error("output pin driven while unused");

  master_clock_a: assert property (
    st.pctl[`SSP_PC_SCL_EN] && !st.pctl[`SSP_PC_SCL_OD]
    |-> !pins.scl_oe_n && pins.scl_out == st.pctl[`SSP_PC_SCL_LVL])
    else $error("clock pin not following software");

  // Clock pin stays an input unless software takes it
  scl_release_a: assert property (
    !st.pctl[`SSP_PC_SCL_EN] |-> pins.scl_oe_n)
    else $error("clock pin driven while released");

endmodule : simple_serial_shift_port

`default_nettype wire

// ---- verilog/sshift_defs.svh ----
// Offsets, field positions, reset values and counts of the serial shift port
`ifndef SSHIFT_DEFS_SVH
`define SSHIFT_DEFS_SVH

// ****************************************
// Register offsets
// ****************************************
`define SSP_OFF_DATA   8'hdd
`define SSP_OFF_DISARM 8'hc2
`define SSP_OFF_PCTL   8'hc0
`define SSP_OFF_PSTAT  8'hc1
`define SSP_OFF_STAT   8'hc3
`define SSP_OFF_MASK   8'hc4

// ****************************************
// Pin control fields
// ****************************************
`define SSP_PC_SCL_EN  0
`define SSP_PC_SCL_LVL 1
`define SSP_PC_SCL_OD  2
`define SSP_PC_SOUT_OD 3
`define SSP_PC_SIN_LOW 4

// ****************************************
// Reset values and counts
// ****************************************
`define SSP_RST_BYTE   8'h00
`define SSP_RST_CNT    4'h0
`define SSP_RST_PCTL   5'h00
`define SSP_LAST_BIT   4'h7

`endif

// ---- verilog/sshift_pkg.sv ----
// Types shared by the serial shift port
`default_nettype none

package sshift_pkg;

  // Pin drive: out level and active-low output enable per pin
  typedef struct packed {
    logic scl_out;
    logic scl_oe_n;
    logic sin_out;
    logic sin_oe_n;
    logic sout_out;
    logic sout_oe_n;
  } pins_t;

  // Whole state of the port
  typedef struct packed {
    logic [7:0] sh;
    logic [3:0] cnt;
    logic       armed;
    logic       irq_n;
    logic [7:0] disarm;
    logic [4:0] pctl;
    logic       stat;
    logic       mask;
    logic       irq;
    logic       scl_s1;
    logic       scl_s2;
    logic       scl_s3;
    logic       sin_s1;
    logic       sin_s2;
    logic [7:0] rdata;
    pins_t      pins;
  } state_t;

endpackage : sshift_pkg

`default_nettype wire

// ---- tb/serial_master_model.sv ----
// Behavioural external serial master that clocks the port's link
`default_nettype none

module serial_master_model
(
  // Frame request
  input  wire logic       go,
  input  wire logic [7:0] tx_byte,
  input  wire logic [3:0] n_edges,
  output var  logic       busy,
  output var  logic [7:0] rx_byte,
  // Open-drain drives, low pulls the line down
  output var  logic       scl_drv_n,
  output var  logic       sin_drv_n,
  input  wire logic       sout_line
);
  timeunit 1ns;
  timeprecision 1ns;

  // Lines released at time zero, so the pull-ups hold them high
  initial
  begin
    busy      = 1'b0;
    rx_byte   = 8'h00;
    scl_drv_n = 1'b1;
    sin_drv_n = 1'b1;
  end

  // One frame per go; the clock stands high between frames
  always @(posedge go)
  begin
    busy = 1'b1;
    for (int i = 0; i < n_edges; i++)
    begin
      #20 sin_drv_n = (i < 8) ? tx_byte[7-i] : 1'b0;
      // Sample before the fall, well after the last shift landed
      #20 if (i < 8) rx_byte = {rx_byte[6:0], sout_line};
      scl_drv_n = 1'b0;
      #40 scl_drv_n = 1'b1;
    end
    sin_drv_n = 1'b1;
    #40 busy = 1'b0;
  end

endmodule : serial_master_model

`default_nettype wire

// ---- tb/testbench.sv ----
// Self-checking bench of the serial shift port against an external master
`include "sshift_defs.svh"
`default_nettype none

module testbench;
  timeunit 1ns;
  timeprecision 1ns;

  typedef struct packed { logic [7:0] cpu; logic [7:0] far; logic [3:0] n; } row_t;

  logic              sys_clk, arst_n, clk_en, reg_wr, reg_rd, go, far_busy;
  logic              scl_drv_n, sin_drv_n, byte_irq_n, irq, scl_line, sin_line, sout_line;
  logic [7:0]        reg_addr, reg_wdata, reg_rdata, far_byte, far_rx;
  logic [3:0]        n_edges;
  sshift_pkg::pins_t pins;
  int                errors, checks_done, cycles;
  // Ninth edge in the last row must be ignored
  row_t rows [4] = '{'{8'ha5, 8'h3c, 4'h8}, '{8'h00, 8'hff, 4'h8},
                     '{8'hff, 8'h00, 4'h8}, '{8'h81, 8'h7e, 4'h9}};

  // Wired lines with pull-ups
  assign scl_line  = ~(~scl_drv_n | (~pins.scl_oe_n & ~pins.scl_out));
  assign sin_line  = ~(~sin_drv_n | (~pins.sin_oe_n & ~pins.sin_out));
  assign sout_line = pins.sout_oe_n | pins.sout_out;

  simple_serial_shift_port #(.ADDR_W(8)) u_simple_serial_shift_port
  (
    .sys_clk    (sys_clk),
    .arst_n     (arst_n),
    .clk_en     (clk_en),
    .reg_addr   (reg_addr),
    .reg_wdata  (reg_wdata),
    .reg_wr     (reg_wr),
    .reg_rd     (reg_rd),
    .reg_rdata  (reg_rdata),
    .byte_irq_n (byte_irq_n),
    .irq        (irq),
    .scl_in     (scl_line),
    .sin_in     (sin_line),
    .pins       (pins)
  );

  serial_master_model u_serial_master_model
  (
    .go        (go),
    .tx_byte   (far_byte),
    .n_edges   (n_edges),
    .busy      (far_busy),
    .rx_byte   (far_rx),
    .scl_drv_n (scl_drv_n),
    .sin_drv_n (sin_drv_n),
    .sout_line (sout_line)
  );

  // ****************************************
  // Clock, timeout and shared tasks
  // ****************************************
  initial sys_clk = 1'b0;
  always #5 sys_clk = ~sys_clk;

  // A hang counts as a mismatch
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      errors++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    if (errors == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : report_and_stop

  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // Tasks end 1 ns past the edge so the design's updates have landed
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    #1;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    v = reg_rdata;
  endtask : rd

  task automatic run(input logic [7:0] b, input logic [3:0] n);
    int w = 0;
    far_byte = b;
    n_edges  = n;
    go       = 1'b1;
    @(posedge sys_clk);
    go <= 1'b0;
    while (far_busy === 1'b1 && w < 2000)
    begin
      @(posedge sys_clk);
      w++;
    end
    repeat (8) @(posedge sys_clk);
    #1;
  endtask : run

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    logic [7:0] d;
    {arst_n, reg_wr, reg_rd, go} = 4'h0;
    clk_en    = 1'b1;
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
    far_byte  = 8'h00;
    n_edges   = 4'h0;
    repeat (8) @(posedge sys_clk);
    arst_n <= 1'b1;
    rd(`SSP_OFF_DATA, d);
    chk("data_rst", d, `SSP_RST_BYTE);
    rd(`SSP_OFF_PSTAT, d);
    chk("pstat_rst", d, 8'h07);
    chk("oe_rst", {5'h00, pins.scl_oe_n, pins.sin_oe_n, pins.sout_oe_n}, 8'h07);
    // Shifting runs after reset but no request comes until armed
    run(8'h96, 4'h8);
    chk("irq_n_unarmed", {7'h00, byte_irq_n}, 8'h01);
    rd(`SSP_OFF_DATA, d);
    chk("rx_unarmed", d, 8'h96);
    wr(`SSP_OFF_PCTL, 8'h08);
    wr(`SSP_OFF_STAT, 8'h01);
    wr(`SSP_OFF_MASK, 8'h01);
    for (int k = 0; k < 4; k++)
    begin
      wr(`SSP_OFF_DATA, rows[k].cpu);
      chk("irq_n_armed", {7'h00, byte_irq_n}, 8'h01);
      run(rows[k].far, rows[k].n);
      rd(`SSP_OFF_DATA, d);
      chk("rx_byte", d, rows[k].far);
      chk("tx_byte", far_rx, rows[k].cpu);
      chk("irq_n_done", {7'h00, byte_irq_n}, 8'h00);
      chk("irq_set", {7'h00, irq}, 8'h01);
      wr(`SSP_OFF_STAT, 8'h01);
      repeat (2) @(posedge sys_clk);
      chk("irq_clear", {7'h00, irq}, 8'h00);
    end
    // Disarm after arming: no request at the end of the byte
    wr(`SSP_OFF_DATA, 8'h3c);
    wr(`SSP_OFF_DISARM, 8'h5a);
    run(8'hc3, 4'h8);
    chk("irq_n_disarmed", {7'h00, byte_irq_n}, 8'h01);
    rd(`SSP_OFF_DISARM, d);
    chk("disarm_val", d, 8'h5a);
    // Rewrite mid-byte restarts the count
    wr(`SSP_OFF_DATA, 8'h11);
    run(8'hf0, 4'h4);
    wr(`SSP_OFF_DATA, 8'h22);
    run(8'hf0, 4'h4);
    chk("irq_n_restart", {7'h00, byte_irq_n}, 8'h01);
    run(8'h0f, 4'h4);
    chk("irq_n_late", {7'h00, byte_irq_n}, 8'h00);
    rd(`SSP_OFF_DATA, d);
    chk("rx_restart", d, 8'hf0);
    wr(`SSP_OFF_MASK, 8'h00);
    repeat (2) @(posedge sys_clk);
    chk("irq_masked", {7'h00, irq}, 8'h00);
    rd(`SSP_OFF_STAT, d);
    chk("stat_sticky", d, 8'h01);
    wr(`SSP_OFF_STAT, 8'h01);
    rd(`SSP_OFF_STAT, d);
    chk("stat_w1c", d, 8'h00);
    rd(8'h10, d);
    chk("unmapped", d, 8'h00);
    // A data write while the enable is low must leave the frozen byte alone
    @(posedge sys_clk);
    clk_en <= 1'b0;
    wr(`SSP_OFF_DATA, 8'h55);
    @(posedge sys_clk);
    clk_en <= 1'b1;
    rd(`SSP_OFF_DATA, d);
    chk("rx_frozen", d, 8'hf0);
    chk("irq_n_frozen", {7'h00, byte_irq_n}, 8'h00);
    // Software drives or stretches the clock, then pulls the data line low
    wr(`SSP_OFF_PCTL, 8'h01);
    chk("scl_drive", {7'h00, pins.scl_oe_n}, 8'h00);
    repeat (3) @(posedge sys_clk);
    rd(`SSP_OFF_PSTAT, d);
    chk("scl_level", d & 8'h02, 8'h00);
    wr(`SSP_OFF_PCTL, 8'h10);
    repeat (3) @(posedge sys_clk);
    rd(`SSP_OFF_PSTAT, d);
    chk("sin_level", d & 8'h01, 8'h00);
    // Master byte: software toggles the clock line, the idle data line shifts in ones
    wr(`SSP_OFF_PCTL, 8'h03);
    wr(`SSP_OFF_DATA, 8'h5a);
    for (int j = 0; j < 8; j++)
    begin
      wr(`SSP_OFF_PCTL, 8'h01);
      wr(`SSP_OFF_PCTL, 8'h03);
    end
    repeat (2) @(posedge sys_clk);
    rd(`SSP_OFF_DATA, d);
    chk("sw_clk_rx", d, 8'hff);
    chk("sw_clk_irq_n", {7'h00, byte_irq_n}, 8'h00);
    // Reset after a finished byte while armed and requesting: request withdrawn, then disarmed
    @(posedge sys_clk);
    arst_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    chk("irq_n_in_rst", {7'h00, byte_irq_n}, 8'h01);
    arst_n <= 1'b1;
    run(8'h69, 4'h8);
    chk("irq_n_after_rst", {7'h00, byte_irq_n}, 8'h01);
    rd(`SSP_OFF_DATA, d);
    chk("rx_after_rst", d, 8'h69);
    report_and_stop();
  end

endmodule : testbench

`default_nettype wire
